// ===== tdc_defs.svh
// Offsets, field positions, reset values and figures of the timer DMA channel block
`ifndef TDC_DEFS_SVH
`define TDC_DEFS_SVH

// ==========================================================
// APB byte offsets, one aligned 32-bit word per register
`define TDC_OFS_DMA_COUNTER_POINTER_REG    12'h000
`define TDC_OFS_DMA_ADDRESS_POINTER_REG    12'h004
`define TDC_OFS_IRQ_DMA_MASK_REG    12'h008
`define TDC_OFS_CTRL    12'h00C
`define TDC_OFS_FLAG    12'h010
`define TDC_OFS_CMP0    12'h014
`define TDC_OFS_CAP0    12'h018

// ==========================================================
// Pointer register fields
`define TDC_PTR_WSEL    0
`define TDC_PTR_TOG     2
`define TDC_PTR_HI      7
`define TDC_PTR_LO      3

// ==========================================================
// Interrupt and DMA mask register fields
`define TDC_IM_CMP      0
`define TDC_IM_CAP      1
`define TDC_IM_OUF      2
`define TDC_DM_CMP      3
`define TDC_DM_CAP      4
`define TDC_GEN         7

// ==========================================================
// Control register fields
`define TDC_CT_SWAP     0
`define TDC_CT_EOB_WRITE_ENABLE_BIT     1
`define TDC_CT_PRIO_HI  4
`define TDC_CT_PRIO_LO  2

// ==========================================================
// Flag register fields
`define TDC_FL_PND_CMP  0
`define TDC_FL_PND_CAP  1
`define TDC_FL_PND_OUF  2
`define TDC_FL_OVR_CMP  3
`define TDC_FL_OVR_CAP  4
`define TDC_FL_EOB_CMP  5
`define TDC_FL_EOB_CAP  6

// ==========================================================
// Reset values and fixed levels
`define TDC_RST_BYTE    8'h00
`define TDC_RST_WORD    16'h0000
`define TDC_PRIO_TOP    3'h0

`endif

// ===== tdc_pkg.sv
// Types shared by the timer DMA channel block
package tdc_pkg;

	// ======================================================
	// Sequencer states of one word transfer
	typedef enum logic [1:0] {
		TDC_IDLE  = 2'b00,	// No word in flight
		TDC_BYTE1 = 2'b01,	// First (high) byte requested
		TDC_BYTE2 = 2'b10	// Second (low) byte requested
	} tdc_state_t;

	// ======================================================
	// Request towards the core DMA controller
	typedef struct packed {
		logic       req;	// Byte transfer wanted
		logic       chan;	// 1 capture channel, 0 compare channel
		logic       second;	// Low byte of the word
		logic [2:0] prio;	// Peripheral request level
		logic [7:0] cnt_ptr;	// Transaction counter pointer address
		logic [7:0] addr_ptr;	// Address pointer address
		logic [7:0] rdata;	// Capture byte offered to the controller
	} tdc_dma_req_t;

	// ======================================================
	// Answer from the core DMA controller
	typedef struct packed {
		logic       ack;	// Byte moved this cycle
		logic       tc_zero;	// Transaction counter reached zero
		logic [7:0] wdata;	// Byte delivered for the compare register
	} tdc_dma_ack_t;

	// ======================================================
	// Whole state of the channel block
	typedef struct packed {
		tdc_state_t  fsm;	// Word sequencer
		logic        chan;	// Channel being served
		logic [7:0]  dma_counter_pointer_reg;	// Counter pointer register
		logic [7:0]  dma_address_pointer_reg;	// Address pointer register
		logic [7:0]  irq_dma_mask_reg;	// Interrupt and DMA mask register
		logic [7:0]  ctrl;	// Control register
		logic [7:0]  flag;	// Timer flag register
		logic [15:0] cmp0;	// First compare register
		logic [15:0] cap0;	// First capture register
		logic [31:0] prdata;	// Read data staged in setup phase
	} tdc_state_s_t;

endpackage

// ===== tdc_arb.sv
// Fixed priority channel arbiter with lock during a word
`timescale 1ns/10ps
`include "tdc_defs.svh"

module tdc_arb (
	input  wire logic req_cap,	// Capture channel asks
	input  wire logic req_cmp,	// Compare channel asks
	input  wire logic locked,	// Word already in flight
	input  wire logic cur_chan,	// Channel of the word in flight
	output logic      grant_vld,	// A channel is granted
	output logic      grant_chan	// Granted channel, 1 capture
);

	// ======================================================
	// Grant selection
	// Lock first, so a late request cannot split a word
	always_comb begin
		grant_vld  = 1'b0;
		grant_chan = 1'b0;
		if (locked) begin
			grant_vld  = 1'b1;
			grant_chan = cur_chan;
		end else if (req_cap) begin
			grant_vld  = 1'b1;
			grant_chan = 1'b1;
		end else if (req_cmp) begin
			grant_vld  = 1'b1;
			grant_chan = 1'b0;
		end
	end

endmodule // tdc_arb

// ===== tdc_dma.sv
// Timer DMA channel block: pointers, word sequencing, end of block and APB registers
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/10ps
`include "tdc_defs.svh"

// Function
// - compare-in and capture-out DMA channels
// - capture channel beats compare channel
// - each channel gated by own mask
// - upper pointer bits shared by channels
// - bit1 replaced by inverted channel in word mode
// - word select one uses single pointer group
// - word moves as two byte transfers
// - second byte at top priority level
// - word channel holds until both bytes
// - counter zero raises end of block
// - swap toggles pointer bit two
// - each channel has own toggle bit
// - one swap enable for both channels
// - block end interrupt after DMA idle
// - overflow interrupt beats block end
// - software one sets block end flag
// - repeated block end clears DMA mask
// - recurring compare or capture event sets overrun flag
// - global enable masks all interrupts
module tdc_dma (
	input  wire logic                 clk_sys,	// Core clock
	input  wire logic                 nrst,	// Async reset, low
	input  wire logic                 psel,	// APB select
	input  wire logic                 penable,	// APB access phase
	input  wire logic                 pwrite,	// APB write
	input  wire logic [11:0]          paddr,	// APB byte address
	input  wire logic [31:0]          pwdata,	// APB write data
	output logic [31:0]               prdata,	// APB read data
	output logic                      pready,	// APB ready
	output logic                      pslverr,	// APB error
	input  wire logic                 compare_zero_event,	// Compare 0 match
	input  wire logic                 capture_zero_event,	// Capture 0 strobe
	input  wire logic                 overflow_underflow_event,	// Counter wrap
	input  wire logic [15:0]          capture_value,	// Counter at capture
	output logic [15:0]               compare_value,	// First compare register
	output tdc_pkg::tdc_dma_req_t     dma_req,	// Request to DMA controller
	input  wire tdc_pkg::tdc_dma_ack_t dma_ack,	// Answer from DMA controller
	output logic                      irq_req,	// Interrupt request level
	output logic [2:0]                irq_level	// Group level of the request
);
	import tdc_pkg::*;

	// ======================================================
	// State and helpers
	// All state lives in one struct, registered in one place
	tdc_state_s_t q;	// Registered state
	tdc_state_s_t d;	// Next state
	logic         req_cap;	// Capture channel wants DMA
	logic         req_cmp;	// Compare channel wants DMA
	logic         grant_vld;	// Arbiter granted
	logic         grant_chan;	// Arbiter channel
	logic         rd_hit;	// Read address decodes
	logic [31:0]  rd_val;	// Read mux value
	logic         acc;	// APB access phase
	logic         wr;	// APB write strobe
	logic         tog;	// Toggle bit of served channel
	logic         irq_ouf;	// Overflow interrupt wanted
	logic         irq_cap;	// Capture group interrupt wanted
	logic         irq_cmp;	// Compare group interrupt wanted

	// ======================================================
	// Register read decode, used for data and for error
	// Unmapped offsets give zero data with the hit bit low
	function automatic logic [32:0] reg_read(input logic [11:0] a, input tdc_state_s_t s);
		logic [32:0] r;
		r = {1'b1, 32'h0000_0000};
		unique case (a)
			`TDC_OFS_DMA_COUNTER_POINTER_REG: r[7:0]  = s.dma_counter_pointer_reg;
			`TDC_OFS_DMA_ADDRESS_POINTER_REG: r[7:0]  = s.dma_address_pointer_reg;
			`TDC_OFS_IRQ_DMA_MASK_REG: r[7:0]  = s.irq_dma_mask_reg;
			`TDC_OFS_CTRL: r[7:0]  = s.ctrl;
			`TDC_OFS_FLAG: r[7:0]  = s.flag;
			`TDC_OFS_CMP0: r[15:0] = s.cmp0;
			`TDC_OFS_CAP0: r[15:0] = s.cap0;
			default:       r[32]   = 1'b0;
		endcase
		return r;
	endfunction

	// ======================================================
	// Pointer address for the served channel
	// Word mode puts the inverted channel on bit 1 (1 for compare) and takes bit 0 from lsb
	// Bits 7 to 3 come from the shared register, bit 2 from the served toggle
	function automatic logic [7:0] ptr_addr(input logic [7:0] base, input logic t,
		input logic ch, input logic lsb);
		return {base[`TDC_PTR_HI:`TDC_PTR_LO], t, ~ch, lsb};
	endfunction

	// APB slave has no wait states; errors only on unmapped offsets
	// Read data is staged in setup so it stands through the access
	assign acc     = psel & penable;
	assign wr      = acc & pwrite;
	assign pready  = 1'b1;
	assign {rd_hit, rd_val} = reg_read(paddr, q);
	assign pslverr = acc & ~rd_hit;
	assign prdata  = q.prdata;
	assign compare_value = q.cmp0;

	// ======================================================
	// DMA request sources
	// masked event becomes DMA
	assign req_cap = q.flag[`TDC_FL_PND_CAP] & q.irq_dma_mask_reg[`TDC_DM_CAP];
	assign req_cmp = q.flag[`TDC_FL_PND_CMP] & q.irq_dma_mask_reg[`TDC_DM_CMP];
	// Global interrupt enable gates interrupts only, never DMA

	// Arbiter stays locked on the served channel while a word is in flight
	tdc_arb u_arb (
		.req_cap    (req_cap),
		.req_cmp    (req_cmp),
		.locked     (q.fsm != TDC_IDLE),
		.cur_chan   (q.chan),
		.grant_vld  (grant_vld),
		.grant_chan (grant_chan)
	);

	// ======================================================
	// Request outputs, decoded from registered state only
	// own channel toggle bit
	assign tog = q.chan ? q.dma_address_pointer_reg[`TDC_PTR_TOG] : q.dma_counter_pointer_reg[`TDC_PTR_TOG];
	// Pointer fields follow the served channel, not the arbiter's current pick

	always_comb begin
		dma_req        = '0;
		dma_req.req    = (q.fsm != TDC_IDLE);
		dma_req.chan   = q.chan;
		dma_req.second = (q.fsm == TDC_BYTE2);
		if (q.fsm == TDC_BYTE2) begin
			dma_req.prio = `TDC_PRIO_TOP;
		end else begin
			dma_req.prio = q.ctrl[`TDC_CT_PRIO_HI:`TDC_CT_PRIO_LO];
		end
		dma_req.cnt_ptr = ptr_addr(q.dma_counter_pointer_reg, tog, q.chan, 1'b0);
		if (q.dma_counter_pointer_reg[`TDC_PTR_WSEL]) begin
			dma_req.addr_ptr = ptr_addr(q.dma_counter_pointer_reg, tog, q.chan, 1'b1);
		end else begin
			dma_req.addr_ptr = ptr_addr(q.dma_address_pointer_reg, tog, q.chan, 1'b0);
		end
		dma_req.rdata = (q.fsm == TDC_BYTE2) ? q.cap0[7:0] : q.cap0[15:8];
	end

	// ======================================================
	// Interrupt requests
	// Events served by DMA raise no ordinary request
	// Block end waits while any DMA request is pending or in flight
	// global interrupt enable
	always_comb begin
		irq_ouf = q.flag[`TDC_FL_PND_OUF] & q.irq_dma_mask_reg[`TDC_IM_OUF];
		irq_cap = q.irq_dma_mask_reg[`TDC_IM_CAP] &
			((q.flag[`TDC_FL_PND_CAP] & ~q.irq_dma_mask_reg[`TDC_DM_CAP]) |
			(q.flag[`TDC_FL_EOB_CAP] & ~dma_req.req & ~req_cap & ~req_cmp));
		irq_cmp = q.irq_dma_mask_reg[`TDC_IM_CMP] &
			((q.flag[`TDC_FL_PND_CMP] & ~q.irq_dma_mask_reg[`TDC_DM_CMP]) |
			(q.flag[`TDC_FL_EOB_CMP] & ~dma_req.req & ~req_cap & ~req_cmp));
		irq_req   = q.irq_dma_mask_reg[`TDC_GEN] & (irq_ouf | irq_cap | irq_cmp);
		// Level codes follow the fixed group priorities, lowest code first
		irq_level = 3'h0;
		if (irq_ouf) begin
			irq_level = 3'h0;
		end else if (irq_cap) begin
			irq_level = 3'h4;
		end else if (irq_cmp) begin
			irq_level = 3'h6;
		end
	end

	// ======================================================
	// Next state: software writes first, then hardware clears, then hardware sets,
	// so an event landing on a software clear is never lost
	always_comb begin
		logic       done;	// Second byte moved
		logic       end_of_block;	// Block ended on served channel
		logic [7:0] f;	// Working flag value
		logic       served_cap;	// Capture word finished now
		logic       served_cmp;	// Compare word finished now
		done = 1'b0;
		served_cap = 1'b0;
		served_cmp = 1'b0;
		end_of_block  = 1'b0;
		f    = q.flag;
		d    = q;

		// Read data staged in the setup phase
		if (psel & ~penable) begin
			d.prdata = rd_val;
		end

		// Software register writes
		if (wr) begin
			unique case (paddr)
				`TDC_OFS_DMA_COUNTER_POINTER_REG: d.dma_counter_pointer_reg = pwdata[7:0];
				`TDC_OFS_DMA_ADDRESS_POINTER_REG: d.dma_address_pointer_reg = pwdata[7:0];
				`TDC_OFS_IRQ_DMA_MASK_REG: d.irq_dma_mask_reg = pwdata[7:0];
				`TDC_OFS_CTRL: d.ctrl = pwdata[7:0];
				`TDC_OFS_CMP0: d.cmp0 = pwdata[15:0];
				`TDC_OFS_CAP0: d.cap0 = pwdata[15:0];
				`TDC_OFS_FLAG: begin
					// Bits 0 to 4 are plain read and write flags
					f[4:0] = pwdata[4:0];
					if (q.ctrl[`TDC_CT_EOB_WRITE_ENABLE_BIT]) begin
						f[`TDC_FL_EOB_CAP:`TDC_FL_EOB_CMP] = pwdata[6:5];
					end else begin
						f[`TDC_FL_EOB_CAP:`TDC_FL_EOB_CMP] =
							pwdata[6:5] & q.flag[`TDC_FL_EOB_CAP:`TDC_FL_EOB_CMP];
					end
				end
				default: ;
			endcase
		end

		// Word sequencer
		unique case (q.fsm)
			// A new word may start the cycle after the last one ended
			TDC_IDLE: begin
				if (grant_vld) begin
					d.chan = grant_chan;
					d.fsm  = TDC_BYTE1;
				end
			end
			TDC_BYTE1: begin
				if (dma_ack.ack) begin
					if (!q.chan) begin
						d.cmp0[15:8] = dma_ack.wdata;
					end
					d.fsm = TDC_BYTE2;
				end
			end
			// Low byte closes the word; the counter end rides on its ack
			TDC_BYTE2: begin
				if (dma_ack.ack) begin
					if (!q.chan) begin
						d.cmp0[7:0] = dma_ack.wdata;
					end
					done  = 1'b1;
					end_of_block   = dma_ack.tc_zero;
					d.fsm = TDC_IDLE;
				end
			end
			default: d.fsm = TDC_IDLE;
		endcase

		// Split the finished word by channel, so a word done on one channel
		// never hides an overrun on the other
		served_cap = done & q.chan;
		served_cmp = done & ~q.chan;

		// Word served: its request is consumed
		if (done) begin
			if (q.chan) begin
				f[`TDC_FL_PND_CAP] = 1'b0;
			end else begin
				f[`TDC_FL_PND_CMP] = 1'b0;
			end
		end

		// End of block handling on the served channel
		// Mask clear wins over a same cycle software write to the mask
		// With swap set, the toggle moves on every block end, a locked one too
		if (end_of_block) begin
			if (q.chan) begin
				if (q.flag[`TDC_FL_EOB_CAP]) begin
					d.irq_dma_mask_reg[`TDC_DM_CAP] = 1'b0;
				end
				f[`TDC_FL_EOB_CAP] = 1'b1;
				if (q.ctrl[`TDC_CT_SWAP]) begin
					d.dma_address_pointer_reg[`TDC_PTR_TOG] = ~q.dma_address_pointer_reg[`TDC_PTR_TOG];
				end
			end else begin
				if (q.flag[`TDC_FL_EOB_CMP]) begin
					d.irq_dma_mask_reg[`TDC_DM_CMP] = 1'b0;
				end
				f[`TDC_FL_EOB_CMP] = 1'b1;
				if (q.ctrl[`TDC_CT_SWAP]) begin
					d.dma_counter_pointer_reg[`TDC_PTR_TOG] = ~q.dma_counter_pointer_reg[`TDC_PTR_TOG];
				end
			end
		end

		// Timer events set pending flags
		// compare or capture recurrence flags overrun
		if (compare_zero_event) begin
			if (q.flag[`TDC_FL_PND_CMP] & ~served_cmp) begin
				f[`TDC_FL_OVR_CMP] = 1'b1;
			end
			f[`TDC_FL_PND_CMP] = 1'b1;
		end
		if (capture_zero_event) begin
			if (q.flag[`TDC_FL_PND_CAP] & ~served_cap) begin
				f[`TDC_FL_OVR_CAP] = 1'b1;
			end
			f[`TDC_FL_PND_CAP] = 1'b1;
			// Value taken with its strobe; a software write that cycle loses
			d.cap0 = capture_value;
		end
		if (overflow_underflow_event) begin
			f[`TDC_FL_PND_OUF] = 1'b1;
		end

		// Bit 7 is unused and always reads zero
		d.flag    = f;
		d.flag[7] = 1'b0;
	end

	// ======================================================
	// State register
	// Reset branch loads constants only
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			q.fsm    <= TDC_IDLE;
			q.chan   <= 1'b0;
			q.dma_counter_pointer_reg   <= `TDC_RST_BYTE;
			q.dma_address_pointer_reg   <= `TDC_RST_BYTE;
			q.irq_dma_mask_reg   <= `TDC_RST_BYTE;
			q.ctrl   <= `TDC_RST_BYTE;
			q.flag   <= `TDC_RST_BYTE;
			q.cmp0   <= `TDC_RST_WORD;
			q.cap0   <= `TDC_RST_WORD;
			q.prdata <= 32'h0000_0000;
		end else begin
			q <= d;
		end
	end

endmodule // tdc_dma

// ===== tdc_mem_model.sv
// Behavioural core DMA controller and memory facing the timer channels
`timescale 1ns/10ps
module tdc_mem_model
	import tdc_pkg::*;
(
	input  wire logic         clk_sys,	// Core clock
	input  wire logic         nrst,	// Reset, low
	input  wire logic [3:0]   dly,	// Wait cycles before each ack
	input  wire logic         last,	// Counter ends with this word
	input  wire logic [15:0]  wword,	// Word fed to compare channel
	input  wire tdc_dma_req_t dma_req,	// Request from timer
	output tdc_dma_ack_t      dma_ack,	// Answer to timer
	output logic [15:0]       word	// Last capture word stored
);
	logic [3:0] wait_q;	// Cycles waited on this byte
	logic       ack_q;	// Ack pulse
	logic [7:0] hi_q;	// Stored high byte
	logic [7:0] b;	// Byte due now

	// ==========================================================
	// Answer path
	// high then low
	assign b = dma_req.second ? wword[7:0] : wword[15:8];
	assign dma_ack = {ack_q, ack_q & dma_req.second & last, ack_q ? b : ~b};

	// ==========================================================
	// Ack after dly cycles; never two acks in a row
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			wait_q <= 4'h0;
			ack_q  <= 1'b0;
			hi_q   <= 8'h00;
			word   <= 16'h0000;
		end else begin
			ack_q  <= 1'b0;
			wait_q <= 4'h0;
			if (dma_req.req && !ack_q) begin
				if (wait_q == dly) ack_q <= 1'b1;
				else wait_q <= wait_q + 4'h1;
			end
			// Capture bytes land in memory
			if (ack_q && dma_req.chan) begin
				if (dma_req.second) word <= {hi_q, dma_req.rdata};
				else hi_q <= dma_req.rdata;
			end
		end
	end
endmodule // tdc_mem_model

// ===== tdc_dma_assertions.sv
// Concurrent checks on the DMA side and interrupt ports of the timer channel block
`timescale 1ns/10ps
module tdc_dma_assertions
	import tdc_pkg::*;
(
	input wire logic         clk_sys,	// Core clock
	input wire logic         nrst,	// Reset, low
	input wire tdc_dma_req_t dma_req,	// Request out
	input wire tdc_dma_ack_t dma_ack,	// Answer in
	input wire logic         irq_req,	// Interrupt level
	input wire logic [2:0]   irq_level	// Group level
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	// ==========================================================
	// Word sequencing
	property p_prio2; dma_req.req && dma_req.second |-> dma_req.prio == 3'h0; endproperty
	a_prio2: assert property (p_prio2) else $error("second byte not top level");
	property p_hold; dma_req.req && !dma_ack.ack |=> dma_req.req && $stable(dma_req.chan);
	endproperty
	a_hold: assert property (p_hold) else $error("request dropped or switched");
	property p_byte2;
		dma_req.req && dma_ack.ack && !dma_req.second
		|=> dma_req.req && dma_req.second && $stable(dma_req.chan);
	endproperty
	a_byte2: assert property (p_byte2) else $error("no low byte after high");
	property p_end; dma_req.req && dma_ack.ack && dma_req.second |=> !dma_req.req; endproperty
	a_end: assert property (p_end) else $error("request after low byte");
	property p_first; $rose(dma_req.req) |-> !dma_req.second; endproperty
	a_first: assert property (p_first) else $error("word began on low byte");

	// ==========================================================
	// Pointer addressing and interrupt level
	property p_bit1; dma_req.req |-> dma_req.cnt_ptr[1:0] == {~dma_req.chan, 1'b0}; endproperty
	a_bit1: assert property (p_bit1) else $error("bit one not channel");
	property p_tog; dma_req.req |-> dma_req.addr_ptr[2:1] == dma_req.cnt_ptr[2:1]; endproperty
	a_tog: assert property (p_tog) else $error("pointer pair split");
	property p_rr;
		dma_req.req && dma_req.addr_ptr[0] |-> dma_req.addr_ptr[7:1] == dma_req.cnt_ptr[7:1];
	endproperty
	a_rr: assert property (p_rr) else $error("single group not adjacent");
	property p_lvl; irq_req |-> irq_level inside {3'h0, 3'h4, 3'h6}; endproperty
	a_lvl: assert property (p_lvl) else $error("bad interrupt level");
endmodule // tdc_dma_assertions

bind tdc_dma tdc_dma_assertions u_chk (
	.clk_sys(clk_sys), .nrst(nrst), .dma_req(dma_req), .dma_ack(dma_ack),
	.irq_req(irq_req), .irq_level(irq_level)
);

// ===== tdc_dma_bench.sv
// Self-checking bench of the timer DMA channel block
`timescale 1ns/10ps
`include "tdc_defs.svh"
module tdc_dma_bench;
	import tdc_pkg::*;
	logic         clk_sys = 0, nrst = 0;	// Clock and reset
	logic         psel = 0, penable = 0, pwrite = 0;	// APB control
	logic [11:0]  paddr = 0;	// APB address
	logic [31:0]  pwdata = 0, prdata, rd;	// APB data, last read
	logic         pready, pslverr, err;	// APB answer, last error
	logic         ev_cmp = 0, ev_cap = 0, ev_ouf = 0;	// Timer events
	logic [15:0]  cap_v = 16'h1234, cmp_v, word;	// Words in and out
	logic [3:0]   dly = 0;	// Model ack delay
	logic         last = 0;	// Model counter end
	tdc_dma_req_t dma_req;	// Request to model
	tdc_dma_ack_t dma_ack;	// Answer from model
	logic         irq_req;	// Interrupt level
	logic [2:0]   irq_level;	// Interrupt group
	int           miscompares = 0, num_checks = 0;	// Tallies

	always #5 clk_sys = ~clk_sys;

	tdc_dma dut (.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .compare_zero_event(ev_cmp),
		.capture_zero_event(ev_cap), .overflow_underflow_event(ev_ouf),
		.capture_value(cap_v), .compare_value(cmp_v), .dma_req(dma_req),
		.dma_ack(dma_ack), .irq_req(irq_req), .irq_level(irq_level));
	tdc_mem_model u_mem (.clk_sys(clk_sys), .nrst(nrst), .dly(dly), .last(last),
		.wword(16'hABCD), .dma_req(dma_req), .dma_ack(dma_ack), .word(word));

	// ==========================================================
	// Verdict, reached from the end and from every timeout
	task complete_run;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask
	// One APB transfer; held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_sys);
		psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk_sys);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin miscompares++; complete_run; end
		rd = prdata;
		err = pslverr;
		psel <= 0; penable <= 0;
	endtask
	task rdc(input string n, input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk(n, e, rd);
	endtask
	// One-cycle event pulses {overflow, capture, compare}
	task ev(input logic [2:0] e);
		@(posedge clk_sys);
		{ev_ouf, ev_cap, ev_cmp} <= e;
		@(posedge clk_sys);
		{ev_ouf, ev_cap, ev_cmp} <= 3'b000;
	endtask
	// Bounded wait for the request level; sampled after the edge settles
	task wt(input logic v);
		int i;
		for (i = 0; i < 60; i++) begin
			@(posedge clk_sys); #1;
			if (dma_req.req === v) break;
		end
		if (i == 60) begin miscompares++; complete_run; end
	endtask
	task settle;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		repeat (6) @(posedge clk_sys);
		nrst <= 1;
		apb(1, `TDC_OFS_DMA_COUNTER_POINTER_REG, 32'h0000_0040); apb(1, `TDC_OFS_DMA_ADDRESS_POINTER_REG, 32'h0000_0080);
		apb(1, `TDC_OFS_CTRL, 32'h0000_000C); apb(1, `TDC_OFS_IRQ_DMA_MASK_REG, 32'h0000_0098);
		ev(3'b011); wt(1);
		chk("chan", 1, dma_req.chan);
		chk("prio", 3, dma_req.prio);
		chk("cptr", 8'h40, dma_req.cnt_ptr);
		chk("aptr", 8'h80, dma_req.addr_ptr);
		wt(0); chk("capword", 16'h1234, word);
		wt(1); chk("cptr", 8'h42, dma_req.cnt_ptr);
		wt(0); chk("cmpval", 16'hABCD, cmp_v);
		// Swap on, capture asks in mid compare word
		apb(1, `TDC_OFS_CTRL, 32'h0000_000D); last <= 1; dly <= 3;
		ev(3'b001); wt(1); ev(3'b010); wt(0); wt(1);
		chk("chan", 1, dma_req.chan);
		chk("cptr", 8'h40, dma_req.cnt_ptr);
		wt(0); rdc("flag", `TDC_OFS_FLAG, 32'h0000_0060);
		rdc("dma_counter_pointer_reg", `TDC_OFS_DMA_COUNTER_POINTER_REG, 32'h0000_0044);
		rdc("dma_address_pointer_reg", `TDC_OFS_DMA_ADDRESS_POINTER_REG, 32'h0000_0084);
		ev(3'b001); wt(1); chk("cptr", 8'h46, dma_req.cnt_ptr);
		wt(0); rdc("irq_dma_mask_reg", `TDC_OFS_IRQ_DMA_MASK_REG, 32'h0000_0090);
		rdc("flag", `TDC_OFS_FLAG, 32'h0000_0060);
		rdc("dma_counter_pointer_reg", `TDC_OFS_DMA_COUNTER_POINTER_REG, 32'h0000_0040);
		// Interrupt levels and global enable
		last <= 0; apb(1, `TDC_OFS_IRQ_DMA_MASK_REG, 32'h0000_0091); settle;
		chk("irqlvl", 3'h6, {irq_req, irq_level} == 4'hE ? 3'h6 : 3'h7);
		apb(1, `TDC_OFS_IRQ_DMA_MASK_REG, 32'h0000_0095); ev(3'b100); settle;
		chk("irqlvl", 4'h8, {irq_req, irq_level});
		apb(1, `TDC_OFS_IRQ_DMA_MASK_REG, 32'h0000_0015); settle;
		chk("irq", 0, irq_req);
		// Software block end
		apb(1, `TDC_OFS_FLAG, 0); apb(1, `TDC_OFS_CTRL, 32'h0000_000E);
		apb(1, `TDC_OFS_FLAG, 32'h0000_0040); rdc("flag", `TDC_OFS_FLAG, 32'h0000_0040);
		apb(1, `TDC_OFS_IRQ_DMA_MASK_REG, 32'h0000_0082); settle;
		chk("irqlvl", 3'h4, irq_req ? irq_level : 3'h7);
		// No DMA mask: pending, overrun, no request
		apb(1, `TDC_OFS_FLAG, 0); apb(1, `TDC_OFS_IRQ_DMA_MASK_REG, 0);
		ev(3'b001); ev(3'b001); settle;
		chk("req", 0, dma_req.req);
		rdc("flag", `TDC_OFS_FLAG, 32'h0000_0009);
		chk("okerr", 0, err);
		// Register to register pointer group
		apb(1, `TDC_OFS_FLAG, 0); apb(1, `TDC_OFS_DMA_COUNTER_POINTER_REG, 32'h0000_0041);
		apb(1, `TDC_OFS_IRQ_DMA_MASK_REG, 32'h0000_0010); cap_v <= 16'h5678; dly <= 0;
		ev(3'b010); wt(1);
		// Capture toggle bit is still set from the swap run
		chk("aptr", 8'h45, dma_req.addr_ptr);
		chk("cptr", 8'h44, dma_req.cnt_ptr);
		wt(0); chk("capword", 16'h5678, word);
		rdc("unmapped", 12'hFFC, 0);
		chk("slverr", 1, err);
		complete_run;
	end
endmodule // tdc_dma_bench
